// *** hw/lpcg_defs.vh ***
`ifndef LPCG_DEFS_VH
`define LPCG_DEFS_VH

// register byte offsets
`define LPCG_OFS_RUN_CFG 12'h060
`define LPCG_OFS_RUN_GATE 12'h104
`define LPCG_OFS_SLEEP_GATE 12'h114
`define LPCG_OFS_DEEP_GATE 12'h124
`define LPCG_OFS_IRQ_STAT 12'h130
`define LPCG_OFS_IRQ_MASK 12'h134
`define LPCG_OFS_GATE_NOW 12'h138
`define LPCG_OFS_FAULT_INFO 12'h13c

// writable bits of every gating register
`define LPCG_GATE_MASK 32'h0107_1013
`define LPCG_GATE_RESET 32'h0000_0000

// gating bit positions
`define LPCG_POS_ASYNC0 0
`define LPCG_POS_ASYNC1 1
`define LPCG_POS_SYNC 4
`define LPCG_POS_TWO_WIRE 12
`define LPCG_POS_GP_COUNTER_ZERO_GATE 16
`define LPCG_POS_GP_COUNTER_ONE_GATE 17
`define LPCG_POS_GP_COUNTER_TWO_GATE 18
`define LPCG_POS_COMP 24

// run-mode clock configuration
`define LPCG_POS_ACG 27
`define LPCG_RUN_CFG_RESET 1'b0

// interrupt status bits
`define LPCG_IRQ_FAULT 0
`define LPCG_IRQ_SLEEP 1
`define LPCG_IRQ_DEEP 2
`define LPCG_IRQ_WAKE 3
`define LPCG_IRQ_RESET 4'h0

// power modes
`define LPCG_MODE_RUN 2'h0
`define LPCG_MODE_SLEEP 2'h1
`define LPCG_MODE_DEEP 2'h2

`endif

// *** hw/lpcg_top.v ***
// Overview of operation
// - each enable bit clocks its peripheral when one, stops and disables it when zero.
// - an access to a peripheral whose clock is off gets a bus fault.
// - every gating enable clears to zero on reset.
// - reserved bits are read-only and read zero; software preserves them.
// - run, sleep and deep-sleep gating registers share one layout.
// - sleep and deep-sleep registers apply only while auto gating is set.
// - bit 0 gates the first asynchronous serial port.
// - bit 1 gates the second asynchronous serial port.
// - bit 4 gates the synchronous serial port.
// - bit 12 gates the two-wire serial controller.
// - bit 16 gates the first timer.
// - bit 17 gates the second timer.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`include "lpcg_defs.vh"

module lpcg_top (
    input wire clock_i,
    input wire rst_i,
    input wire [11:0] addr_i,
    input wire [31:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    output wire [31:0] rd_data_o,
    input wire sleep_req_i,
    input wire deep_req_i,
    input wire wake_i,
    input wire periph_acc_i,
    input wire periph_wr_i,
    input wire [2:0] periph_sel_i,
    output wire periph_fault_o,
    output wire periph_done_o,
    output wire [7:0] unit_clk_en_o,
    output wire [1:0] mode_o,
    output wire irq_o
);

    localparam ST_RUN = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_DEEP = 2'h2;

    reg [31:0] run_gate_reg;
    reg [31:0] sleep_gate_reg;
    reg [31:0] deep_gate_reg;
    reg acg_reg;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_stat_next;
    reg [3:0] irq_mask_reg;
    reg irq_reg;
    reg [31:0] rd_data_reg;
    reg [31:0] rd_data_next;
    reg fault_reg;
    reg done_reg;
    reg [3:0] fault_info_reg;
    reg [3:0] irq_set;
    reg [3:0] irq_clr;

    wire [7:0] unit_run;
    wire [7:0] unit_sleep;
    wire [7:0] unit_deep;
    wire [7:0] unit_en;
    wire [31:0] gate_now;
    wire wr_run_gate;
    wire wr_sleep_gate;
    wire wr_deep_gate;
    wire wr_run_cfg;
    wire wr_irq_mask;
    wire rd_irq_stat;
    wire sel_en;

    // one function serves all three registers since their layouts match
    function [7:0] pick_units;
        input [31:0] r;
        begin
            pick_units[0] = r[`LPCG_POS_ASYNC0];
            pick_units[1] = r[`LPCG_POS_ASYNC1];
            pick_units[2] = r[`LPCG_POS_SYNC];
            pick_units[3] = r[`LPCG_POS_TWO_WIRE];
            pick_units[4] = r[`LPCG_POS_GP_COUNTER_ZERO_GATE];
            pick_units[5] = r[`LPCG_POS_GP_COUNTER_ONE_GATE];
            pick_units[6] = r[`LPCG_POS_GP_COUNTER_TWO_GATE];
            pick_units[7] = r[`LPCG_POS_COMP];
        end
    endfunction

    function [31:0] spread_units;
        input [7:0] u;
        begin
            spread_units = 32'h0000_0000;
            spread_units[`LPCG_POS_ASYNC0] = u[0];
            spread_units[`LPCG_POS_ASYNC1] = u[1];
            spread_units[`LPCG_POS_SYNC] = u[2];
            spread_units[`LPCG_POS_TWO_WIRE] = u[3];
            spread_units[`LPCG_POS_GP_COUNTER_ZERO_GATE] = u[4];
            spread_units[`LPCG_POS_GP_COUNTER_ONE_GATE] = u[5];
            spread_units[`LPCG_POS_GP_COUNTER_TWO_GATE] = u[6];
            spread_units[`LPCG_POS_COMP] = u[7];
        end
    endfunction

    assign wr_run_gate = wr_i && (addr_i == `LPCG_OFS_RUN_GATE);
    assign wr_sleep_gate = wr_i && (addr_i == `LPCG_OFS_SLEEP_GATE);
    assign wr_deep_gate = wr_i && (addr_i == `LPCG_OFS_DEEP_GATE);
    assign wr_run_cfg = wr_i && (addr_i == `LPCG_OFS_RUN_CFG);
    assign wr_irq_mask = wr_i && (addr_i == `LPCG_OFS_IRQ_MASK);
    assign rd_irq_stat = rd_i && (addr_i == `LPCG_OFS_IRQ_STAT);

    // the clock configuration word holds only the auto gating bit
    // three gating registers of one layout; reserved bits never store
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            run_gate_reg <= `LPCG_GATE_RESET;
            sleep_gate_reg <= `LPCG_GATE_RESET;
            deep_gate_reg <= `LPCG_GATE_RESET;
            acg_reg <= `LPCG_RUN_CFG_RESET;
            irq_mask_reg <= `LPCG_IRQ_RESET;
        end
        else
        begin
            if (wr_run_gate)
            begin
                run_gate_reg <= wr_data_i & `LPCG_GATE_MASK;
            end
            if (wr_sleep_gate)
            begin
                sleep_gate_reg <= wr_data_i & `LPCG_GATE_MASK;
            end
            if (wr_deep_gate)
            begin
                deep_gate_reg <= wr_data_i & `LPCG_GATE_MASK;
            end
            if (wr_run_cfg)
            begin
                acg_reg <= wr_data_i[`LPCG_POS_ACG];
            end
            if (wr_irq_mask)
            begin
                irq_mask_reg <= wr_data_i[3:0];
            end
        end
    end

    assign unit_run = pick_units(run_gate_reg);
    assign unit_sleep = pick_units(sleep_gate_reg);
    assign unit_deep = pick_units(deep_gate_reg);

    // power mode sequencing; deep sleep wins when both requests arrive together
    // requests are levels: one still high after wake re-enters low power at once
    always @*
    begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_RUN:
            begin
                if (deep_req_i)
                begin
                    mode_next = ST_DEEP;
                end
                else if (sleep_req_i)
                begin
                    mode_next = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (wake_i)
                begin
                    mode_next = ST_RUN;
                end
            end
            ST_DEEP:
            begin
                if (wake_i)
                begin
                    mode_next = ST_RUN;
                end
            end
            default:
            begin
                mode_next = ST_RUN;
            end
        endcase
    end

    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_reg <= ST_RUN;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    // one gate per unit; the enable is a flop so the clock gate sees no glitch
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_unit
            lpcg_unit_gate u_gate (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .run_en_i(unit_run[gi]),
                .sleep_en_i(unit_sleep[gi]),
                .deep_en_i(unit_deep[gi]),
                .acg_i(acg_reg),
                .mode_i(mode_reg),
                .clk_en_o(unit_en[gi])
            );
        end
    endgenerate

    assign gate_now = spread_units(unit_en);

    // the access is judged against the enable in force at that moment
    assign sel_en = unit_en[periph_sel_i];

    // fault info keeps only the latest refused access; older ones are lost
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fault_reg <= 1'b0;
            done_reg <= 1'b0;
            fault_info_reg <= 4'h0;
        end
        else
        begin
            fault_reg <= periph_acc_i && !sel_en;
            done_reg <= periph_acc_i && sel_en;
            if (periph_acc_i && !sel_en)
            begin
                fault_info_reg <= {periph_wr_i, periph_sel_i};
            end
        end
    end

    // sticky events; a set in the clearing read's cycle survives
    // status is read-and-clear, so software must handle every bit it reads
    always @*
    begin
        irq_set = 4'h0;
        irq_set[`LPCG_IRQ_FAULT] = periph_acc_i && !sel_en;
        irq_set[`LPCG_IRQ_SLEEP] = (mode_reg == ST_RUN) && (mode_next == ST_SLEEP);
        irq_set[`LPCG_IRQ_DEEP] = (mode_reg == ST_RUN) && (mode_next == ST_DEEP);
        irq_set[`LPCG_IRQ_WAKE] = (mode_reg != ST_RUN) && (mode_next == ST_RUN);
        irq_clr = rd_irq_stat ? 4'hf : 4'h0;
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    end

    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_stat_reg <= `LPCG_IRQ_RESET;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            // a mask write counts in its own cycle so the level never lags
            irq_reg <= |(irq_stat_next & (wr_irq_mask ? wr_data_i[3:0] : irq_mask_reg));
        end
    end

    // read mux; unmapped offsets and reserved bits return zero
    always @*
    begin
        rd_data_next = 32'h0000_0000;
        case (addr_i)
            `LPCG_OFS_RUN_CFG:
            begin
                rd_data_next[`LPCG_POS_ACG] = acg_reg;
            end
            `LPCG_OFS_RUN_GATE:
            begin
                rd_data_next = run_gate_reg;
            end
            `LPCG_OFS_SLEEP_GATE:
            begin
                rd_data_next = sleep_gate_reg;
            end
            `LPCG_OFS_DEEP_GATE:
            begin
                rd_data_next = deep_gate_reg;
            end
            `LPCG_OFS_IRQ_STAT:
            begin
                rd_data_next[3:0] = irq_stat_reg;
            end
            `LPCG_OFS_IRQ_MASK:
            begin
                rd_data_next[3:0] = irq_mask_reg;
            end
            `LPCG_OFS_GATE_NOW:
            begin
                rd_data_next = gate_now;
            end
            `LPCG_OFS_FAULT_INFO:
            begin
                rd_data_next[3:0] = fault_info_reg;
                rd_data_next[9:8] = mode_reg;
            end
            default:
            begin
                rd_data_next = 32'h0000_0000;
            end
        endcase
    end

    // data stands for the one cycle after the strobe, zero otherwise
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_data_reg <= 32'h0000_0000;
        end
        else if (rd_i)
        begin
            rd_data_reg <= rd_data_next;
        end
        else
        begin
            rd_data_reg <= 32'h0000_0000;
        end
    end

    // every output comes straight from a flop
    assign rd_data_o = rd_data_reg;
    assign periph_fault_o = fault_reg;
    assign periph_done_o = done_reg;
    assign unit_clk_en_o = unit_en;
    assign mode_o = mode_reg;
    assign irq_o = irq_reg;

endmodule // lpcg_top

// *** hw/lpcg_unit_gate.v ***
`timescale 1ns/100ps
`include "lpcg_defs.vh"

module lpcg_unit_gate (
    input wire clock_i,
    input wire rst_i,
    input wire run_en_i,
    input wire sleep_en_i,
    input wire deep_en_i,
    input wire acg_i,
    input wire [1:0] mode_i,
    output wire clk_en_o
);

    reg en_reg;
    reg en_next;

    always @*
    begin
        en_next = run_en_i;
        // without auto gating the run register also rules the low-power modes
        if (acg_i && (mode_i == `LPCG_MODE_SLEEP))
        begin
            en_next = sleep_en_i;
        end
        else if (acg_i && (mode_i == `LPCG_MODE_DEEP))
        begin
            en_next = deep_en_i;
        end
    end

    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            en_reg <= 1'b0;
        end
        else
        begin
            en_reg <= en_next;
        end
    end

    assign clk_en_o = en_reg;

endmodule // lpcg_unit_gate

// *** sim/lpcg_top_sva.sv ***
`timescale 1ns/100ps
`include "lpcg_defs.vh"

module lpcg_top_chk (
    input wire clock_i,
    input wire rst_i,
    input wire [11:0] addr_i,
    input wire [31:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rd_data_o,
    input wire sleep_req_i,
    input wire deep_req_i,
    input wire wake_i,
    input wire periph_acc_i,
    input wire periph_wr_i,
    input wire [2:0] periph_sel_i,
    input wire periph_fault_o,
    input wire periph_done_o,
    input wire [7:0] unit_clk_en_o,
    input wire [1:0] mode_o,
    input wire irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    function automatic [7:0] pick(input [31:0] r);
        pick = {r[24], r[18], r[17], r[16], r[12], r[4], r[1], r[0]};
    endfunction
    // a write to the run register while running and no mode request
    sequence run_wr;
        wr_i && addr_i == `LPCG_OFS_RUN_GATE && mode_o == `LPCG_MODE_RUN && !sleep_req_i && !deep_req_i;
    endsequence
    sequence quiet;
        !wr_i && !sleep_req_i && !deep_req_i && !wake_i;
    endsequence
    chk_fault_reply: assert property (periph_acc_i && !unit_clk_en_o[periph_sel_i] |=> periph_fault_o)
        else $error("no fault for access to unclocked unit");
    chk_done_reply: assert property (periph_acc_i && unit_clk_en_o[periph_sel_i] |=> periph_done_o)
        else $error("no completion for access to clocked unit");
    chk_idle_reply: assert property (!periph_acc_i |=> !periph_fault_o && !periph_done_o)
        else $error("reply without access");
    chk_reply_exclusive: assert property (!(periph_fault_o && periph_done_o))
        else $error("fault and completion together");
    chk_reset_clear: assert property (disable iff (1'b0) rst_i |=> unit_clk_en_o == 8'h00 && mode_o == 2'h0)
        else $error("enables not cleared by reset");
    chk_reserved_zero: assert property (rd_i && (addr_i == `LPCG_OFS_RUN_GATE || addr_i == `LPCG_OFS_SLEEP_GATE
        || addr_i == `LPCG_OFS_DEEP_GATE || addr_i == `LPCG_OFS_GATE_NOW) |=> (rd_data_o & ~`LPCG_GATE_MASK) == 32'h0)
        else $error("reserved gating bit read nonzero");
    chk_bit_map: assert property (run_wr |=> ##1 unit_clk_en_o == pick($past(wr_data_i, 2)))
        else $error("unit enables do not follow run register bits");
    // enables may only move after a write or a mode change
    chk_gate_hold: assert property (quiet [*2] |=> $stable(unit_clk_en_o))
        else $error("unit enables changed without cause");
endmodule // lpcg_top_chk

bind lpcg_top lpcg_top_chk lpcg_top_chk_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sleep_req_i(sleep_req_i),
    .deep_req_i(deep_req_i), .wake_i(wake_i), .periph_acc_i(periph_acc_i), .periph_wr_i(periph_wr_i),
    .periph_sel_i(periph_sel_i), .periph_fault_o(periph_fault_o), .periph_done_o(periph_done_o),
    .unit_clk_en_o(unit_clk_en_o), .mode_o(mode_o), .irq_o(irq_o));

// *** sim/lpcg_top_tb_top.sv ***
`timescale 1ns/100ps
`include "lpcg_defs.vh"

module lpcg_top_tb_top;
    reg clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sleep_req_i = 0, deep_req_i = 0, wake_i = 0;
    reg periph_acc_i = 0, periph_wr_i = 0;
    reg [11:0] addr_i = 0;
    reg [31:0] wr_data_i = 0;
    reg [2:0] periph_sel_i = 0;
    wire [31:0] rd_data_o;
    wire periph_fault_o, periph_done_o, irq_o;
    wire [7:0] unit_clk_en_o;
    wire [1:0] mode_o;
    integer miscompares = 0, n_checks = 0, i, k;
    reg [31:0] d, v;
    reg [31:0] g [0:2];

    lpcg_top lpcg_top_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sleep_req_i(sleep_req_i), .deep_req_i(deep_req_i),
        .wake_i(wake_i), .periph_acc_i(periph_acc_i), .periph_wr_i(periph_wr_i), .periph_sel_i(periph_sel_i),
        .periph_fault_o(periph_fault_o), .periph_done_o(periph_done_o), .unit_clk_en_o(unit_clk_en_o),
        .mode_o(mode_o), .irq_o(irq_o));

    initial forever #4 clock_i = ~clock_i;

    function [7:0] pick(input [31:0] r);
        pick = {r[24], r[18], r[17], r[16], r[12], r[4], r[1], r[0]};
    endfunction
    function [11:0] ofs(input integer n);
        ofs = n == 0 ? `LPCG_OFS_RUN_GATE : n == 1 ? `LPCG_OFS_SLEEP_GATE : `LPCG_OFS_DEEP_GATE;
    endfunction

    task finish_test;
        begin
            if (miscompares == 0 && n_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] x);
        begin
            @(posedge clock_i);
            wr_i <= 1'b1;
            addr_i <= a;
            wr_data_i <= x;
            @(posedge clock_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, output [31:0] x);
        begin
            @(posedge clock_i);
            rd_i <= 1'b1;
            addr_i <= a;
            @(posedge clock_i);
            rd_i <= 1'b0;
            #1 x = rd_data_o;
        end
    endtask
    // access one unit, fault expected exactly when its enable is low
    task acc(input [2:0] u, input [7:0] en);
        begin
            @(posedge clock_i);
            periph_acc_i <= 1'b1;
            periph_sel_i <= u;
            periph_wr_i <= $urandom;
            @(posedge clock_i);
            periph_acc_i <= 1'b0;
            #1 chk({periph_fault_o, periph_done_o}, en[u] ? 2'b01 : 2'b10);
        end
    endtask
    task go(input sl, input dp, input [1:0] m, input [7:0] e);
        begin
            @(posedge clock_i);
            sleep_req_i <= sl;
            deep_req_i <= dp;
            @(posedge clock_i);
            sleep_req_i <= 1'b0;
            deep_req_i <= 1'b0;
            @(posedge clock_i);
            #1 chk(mode_o, m);
            chk(unit_clk_en_o, e);
            acc($urandom, e);
            @(posedge clock_i);
            wake_i <= 1'b1;
            @(posedge clock_i);
            wake_i <= 1'b0;
        end
    endtask

    initial
    begin
        void'($urandom(76));
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        #1 chk(unit_clk_en_o, 0);
        for (k = 0; k < 3; k = k + 1)
        begin
            rd(ofs(k), v);
            chk(v, 0);
        end
        for (i = 0; i < 8; i = i + 1)
            acc(i, 8'h00);
        rd(`LPCG_OFS_FAULT_INFO, v);
        chk(v, {periph_wr_i, 3'h7});
        wr(`LPCG_OFS_IRQ_MASK, 32'h1);
        #1 chk(irq_o, 1'b1);
        rd(`LPCG_OFS_IRQ_MASK, v);
        chk(v, 32'h1);
        rd(`LPCG_OFS_IRQ_STAT, v);
        chk(v, 32'h1);
        @(posedge clock_i);
        #1 chk(irq_o, 1'b0);
        rd(12'h200, v);
        chk(v, 0);
        wr(`LPCG_OFS_RUN_CFG, 32'hffff_ffff);
        rd(`LPCG_OFS_RUN_CFG, v);
        chk(v, 32'h0800_0000);
        wr(`LPCG_OFS_RUN_CFG, 32'h0);
        // corners first: all ones, then all zeros, then random words
        for (i = 0; i < 30; i = i + 1)
        begin
            k = i % 3;
            d = i < 3 ? 32'hffff_ffff : i < 6 ? 32'h0 : $urandom;
            g[k] = d;
            wr(ofs(k), d);
            rd(ofs(k), v);
            chk(v, d & `LPCG_GATE_MASK);
            rd(`LPCG_OFS_GATE_NOW, v);
            chk(v, g[0] & `LPCG_GATE_MASK);
            chk(unit_clk_en_o, pick(g[0]));
            acc($urandom, pick(g[0]));
        end
        go(1, 0, `LPCG_MODE_SLEEP, pick(g[0]));
        go(0, 1, `LPCG_MODE_DEEP, pick(g[0]));
        wr(`LPCG_OFS_RUN_CFG, 32'h0800_0000);
        go(1, 0, `LPCG_MODE_SLEEP, pick(g[1]));
        go(0, 1, `LPCG_MODE_DEEP, pick(g[2]));
        go(1, 1, `LPCG_MODE_DEEP, pick(g[2]));
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        #1 chk(unit_clk_en_o, 0);
        rd(`LPCG_OFS_RUN_GATE, v);
        chk(v, 0);
        finish_test;
    end

    // hang guard
    initial
    begin
        #400000;
        miscompares = miscompares + 1;
        finish_test;
    end
endmodule // lpcg_top_tb_top
